// ### hw/operand_address_generator.sv
// Operand effective-address generator with stack pointer sequencing.
//
// How it works
// RULE1 - Operand top bit picks first or second pointer.
// RULE2 - Address is pointer top five, operand low three.
// RULE3 - Upper nibble 1100B means working-register operand.
// RULE4 - Eight-bit working form: bit 3 picks pointer.
// RULE5 - Interrupt pushes PC and flags; return pops both.
// RULE6 - Call pushes PC; return reloads PC from stack.
// RULE7 - Decrement before push, increment after pop.
// RULE8 - Stack pointer is sixteen bits, two bytes.
// RULE9 - Stack pointer reset value carries no promise.
// RULE10 - Low byte wrap carries into the high byte.
// RULE11 - Software should start low byte at FFH.
// RULE12 - Indirect: register or pair holds operand address.
// RULE13 - Indirect register cannot reach system area C0H-FFH.
// RULE14 - Indexed cannot reach system area C0H-FFH either.
// RULE15 - Indexed register: instruction base plus register offset.
// RULE16 - Indexed memory: register pair base plus offset.
// RULE17 - Short indexed offset is sign extended.
// RULE18 - Only plain load may index the register file.
// RULE19 - Absolute mode carries a full sixteen-bit address.
// RULE20 - Vector call: zero-extended operand in lowest page.
// RULE21 - Relative: next PC plus signed displacement.
// RULE22 - Listed relative jumps all use relative computation.
// RULE23 - Pair: high byte even register, low byte odd.
// RULE24 - Pointer low three bits are ignored.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps

module operand_address_generator (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire operand_address_pkg::request_t req,
	output logic req_ready,
	output operand_address_pkg::result_t res,
	output operand_address_pkg::stack_port_t stk,
	input wire logic [7:0] stk_rdata,
	output operand_address_pkg::restore_t rest,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata
);

	operand_address_pkg::core_state_t s;
	operand_address_pkg::core_state_t next_s;

	function automatic logic [7:0] work_addr(
		input logic [3:0] nib,
		input logic [7:0] first,
		input logic [7:0] second
	);
		logic [7:0] ptr;
		ptr = nib[3] ? second : first; // see RULE1
		return {ptr[7:3], nib[2:0]}; // see RULE2, see RULE24
	endfunction : work_addr

	function automatic logic [7:0] reg_operand(
		input logic [7:0] op,
		input logic [7:0] first,
		input logic [7:0] second
	);
		if (op[7:4] == operand_address_pkg::WORK_PREFIX) begin // see RULE3
			return work_addr(op[3:0], first, second); // see RULE4
		end
		return op;
	endfunction : reg_operand

	function automatic logic in_system_area(input logic [7:0] a);
		return a >= operand_address_pkg::SYSTEM_AREA_BASE;
	endfunction : in_system_area

	function automatic logic [15:0] sext(input logic [7:0] b);
		return {{8{b[7]}}, b};
	endfunction : sext

	assign req_ready = (s.state == operand_address_pkg::ST_IDLE);
	assign res = s.res;
	assign stk = s.stk;
	assign rest = s.rest;
	assign reg_rdata = s.rdata;

	always_comb begin
		logic [15:0] pair;
		logic [15:0] sum;
		pair = {req.value_high, req.value_low}; // see RULE23
		sum = 16'h0000;
		next_s = s;
		next_s.res.valid = 1'b0;
		next_s.stk.write = 1'b0;
		next_s.stk.read = 1'b0;
		next_s.rest.pc_load = 1'b0;
		next_s.rest.flags_load = 1'b0;
		next_s.rest.pop_valid = 1'b0;
		next_s.rdata = 8'h00;
		next_s.pending = 1'b0;
		if (s.pending) begin
			next_s.gather = {s.gather[15:0], stk_rdata};
		end
		case (s.state)
			operand_address_pkg::ST_IDLE: begin
				if (req.valid) begin
					next_s.cmd = req.cmd;
					next_s.gather = 24'h000000;
					case (req.cmd)
						operand_address_pkg::CMD_PUSH: begin
							next_s.bytes = {16'h0000, req.push_data};
							next_s.count = operand_address_pkg::SINGLE_BYTE;
							next_s.state = operand_address_pkg::ST_PUSH;
						end
						operand_address_pkg::CMD_CALL: begin
							// Low byte goes first so the high byte sits on top.
							next_s.bytes = {8'h00, req.pc[15:8], req.pc[7:0]};
							next_s.count = operand_address_pkg::CALL_BYTES; // see RULE6
							next_s.state = operand_address_pkg::ST_PUSH;
						end
						operand_address_pkg::CMD_INTERRUPT: begin
							next_s.bytes = {req.flags, req.pc[15:8], req.pc[7:0]};
							next_s.count = operand_address_pkg::INTERRUPT_BYTES; // see RULE5
							next_s.state = operand_address_pkg::ST_PUSH;
						end
						operand_address_pkg::CMD_POP: begin
							next_s.count = operand_address_pkg::SINGLE_BYTE;
							next_s.state = operand_address_pkg::ST_POP;
						end
						operand_address_pkg::CMD_RETURN: begin
							next_s.count = operand_address_pkg::CALL_BYTES; // see RULE6
							next_s.state = operand_address_pkg::ST_POP;
						end
						operand_address_pkg::CMD_RETURN_FROM_INTERRUPT: begin
							next_s.count = operand_address_pkg::INTERRUPT_BYTES; // see RULE5
							next_s.state = operand_address_pkg::ST_POP;
						end
						default: begin
							next_s.res.valid = 1'b1;
							next_s.res.bad = 1'b0;
							next_s.res.space = operand_address_pkg::SPACE_REGISTER;
							case (req.mode)
								operand_address_pkg::MODE_WORK4: begin
									next_s.res.addr = {8'h00, work_addr(req.operand[3:0],
										s.slice_first, s.slice_second)};
								end
								operand_address_pkg::MODE_REG8: begin
									next_s.res.addr = {8'h00, reg_operand(req.operand,
										s.slice_first, s.slice_second)};
								end
								operand_address_pkg::MODE_POINTER_REG: begin
									next_s.res.addr = {8'h00, req.value_low}; // see RULE12
									next_s.res.bad = in_system_area(req.value_low); // see RULE13
								end
								operand_address_pkg::MODE_POINTER_PAIR: begin
									next_s.res.addr = pair; // see RULE12
									if (req.insn == operand_address_pkg::INSN_PROGRAM_MEMORY_LOAD) begin
										next_s.res.space = operand_address_pkg::SPACE_PROGRAM;
									end else begin
										next_s.res.space = operand_address_pkg::SPACE_EXTERNAL;
									end
								end
								operand_address_pkg::MODE_INDEX_REG: begin
									sum[7:0] = req.operand + req.value_low; // see RULE15
									next_s.res.addr = {8'h00, sum[7:0]};
									next_s.res.bad = in_system_area(sum[7:0]) || // see RULE14
										(req.insn != operand_address_pkg::INSN_LOAD); // see RULE18
								end
								operand_address_pkg::MODE_INDEX_SHORT,
								operand_address_pkg::MODE_INDEX_LONG: begin
									if (req.mode == operand_address_pkg::MODE_INDEX_SHORT) begin
										sum = pair + sext(req.operand); // see RULE16, see RULE17
									end else begin
										sum = pair + req.word; // see RULE16
									end
									next_s.res.addr = sum;
									if (req.insn == operand_address_pkg::INSN_PROGRAM_MEMORY_LOAD) begin
										next_s.res.space = operand_address_pkg::SPACE_PROGRAM;
									end else if (req.insn ==
										operand_address_pkg::INSN_EXTERNAL_DATA_LOAD) begin
										next_s.res.space = operand_address_pkg::SPACE_EXTERNAL;
									end else begin
										next_s.res.bad = 1'b1; // see RULE18
									end
								end
								operand_address_pkg::MODE_ABSOLUTE: begin
									next_s.res.addr = req.word; // see RULE19
									case (req.insn)
										operand_address_pkg::INSN_ABSOLUTE_JUMP,
										operand_address_pkg::INSN_CALL: begin
											next_s.res.space = operand_address_pkg::SPACE_PC;
										end
										operand_address_pkg::INSN_PROGRAM_MEMORY_LOAD: begin
											next_s.res.space = operand_address_pkg::SPACE_PROGRAM;
										end
										operand_address_pkg::INSN_EXTERNAL_DATA_LOAD: begin
											next_s.res.space = operand_address_pkg::SPACE_EXTERNAL;
										end
										default: begin
											next_s.res.bad = 1'b1;
										end
									endcase
								end
								operand_address_pkg::MODE_VECTOR: begin
									// The vector pair is read by the fetch side; only its spot is formed.
									next_s.res.addr = {operand_address_pkg::VECTOR_PAGE,
										req.operand}; // see RULE20
									next_s.res.space = operand_address_pkg::SPACE_PROGRAM;
									next_s.res.bad = (req.insn != operand_address_pkg::INSN_CALL);
								end
								operand_address_pkg::MODE_PC_OFFSET: begin
									next_s.res.addr = req.pc + sext(req.operand); // see RULE21
									next_s.res.space = operand_address_pkg::SPACE_PC;
									case (req.insn)
										operand_address_pkg::INSN_RELATIVE_JUMP,
										operand_address_pkg::INSN_BIT_FALSE_REL_JUMP,
										operand_address_pkg::INSN_BIT_TRUE_REL_JUMP,
										operand_address_pkg::INSN_DECREMENT_NONZERO_JUMP,
										operand_address_pkg::INSN_COMPARE_INC_EQUAL_JUMP,
										operand_address_pkg::INSN_COMPARE_INC_UNEQUAL_JUMP: begin
											next_s.res.bad = 1'b0; // see RULE22
										end
										default: begin
											next_s.res.bad = 1'b1;
										end
									endcase
								end
								default: begin
									next_s.res.addr = 16'h0000;
									next_s.res.bad = 1'b1;
								end
							endcase
						end
					endcase
				end
			end
			operand_address_pkg::ST_PUSH: begin
				// Carry or borrow into the high byte is plain 16-bit arithmetic.
				next_s.sp = s.sp - 16'h0001; // see RULE7, see RULE10
				next_s.stk.addr = next_s.sp[7:0];
				next_s.stk.write = 1'b1;
				next_s.stk.wdata = s.bytes[7:0];
				next_s.bytes = {8'h00, s.bytes[23:8]};
				next_s.count = s.count - 2'h1;
				if (s.count == 2'h1) begin
					next_s.res.valid = 1'b1;
					next_s.res.bad = 1'b0;
					next_s.res.space = operand_address_pkg::SPACE_REGISTER;
					next_s.res.addr = next_s.sp;
					next_s.state = operand_address_pkg::ST_IDLE;
				end
			end
			operand_address_pkg::ST_POP: begin
				// Read data is taken at the end of the read pulse itself, so the
				// register file must answer within that same cycle.
				next_s.stk.addr = s.sp[7:0];
				next_s.stk.read = 1'b1;
				next_s.pending = 1'b1;
				next_s.sp = s.sp + 16'h0001; // see RULE7, see RULE10
				next_s.count = s.count - 2'h1;
				if (s.count == 2'h1) begin
					next_s.state = operand_address_pkg::ST_POP_END;
				end
			end
			operand_address_pkg::ST_POP_END: begin
				next_s.res.valid = 1'b1;
				next_s.res.bad = 1'b0;
				next_s.res.space = operand_address_pkg::SPACE_REGISTER;
				next_s.res.addr = s.sp;
				case (s.cmd)
					operand_address_pkg::CMD_RETURN: begin
						next_s.rest.pc = next_s.gather[15:0]; // see RULE6
						next_s.rest.pc_load = 1'b1;
					end
					operand_address_pkg::CMD_RETURN_FROM_INTERRUPT: begin
						next_s.rest.flags = next_s.gather[23:16]; // see RULE5
						next_s.rest.flags_load = 1'b1;
						next_s.rest.pc = next_s.gather[15:0];
						next_s.rest.pc_load = 1'b1;
					end
					default: begin
						next_s.rest.pop_data = next_s.gather[7:0];
						next_s.rest.pop_valid = 1'b1;
					end
				endcase
				next_s.state = operand_address_pkg::ST_IDLE;
			end
			default: begin
				next_s.state = operand_address_pkg::ST_IDLE;
			end
		endcase
		// A software write lands after the stack engine and so takes precedence.
		if (reg_write) begin
			case (reg_addr)
				operand_address_pkg::SLICE_FIRST_OFFSET: begin
					next_s.slice_first = reg_wdata;
				end
				operand_address_pkg::SLICE_SECOND_OFFSET: begin
					next_s.slice_second = reg_wdata;
				end
				operand_address_pkg::STACK_HIGH_OFFSET: begin
					next_s.sp[15:8] = reg_wdata; // see RULE8
				end
				operand_address_pkg::STACK_LOW_OFFSET: begin
					next_s.sp[7:0] = reg_wdata; // see RULE8
				end
				default: begin
				end
			endcase
		end
		if (reg_read) begin
			case (reg_addr)
				operand_address_pkg::SLICE_FIRST_OFFSET: begin
					next_s.rdata = s.slice_first;
				end
				operand_address_pkg::SLICE_SECOND_OFFSET: begin
					next_s.rdata = s.slice_second;
				end
				operand_address_pkg::STACK_HIGH_OFFSET: begin
					next_s.rdata = s.sp[15:8];
				end
				operand_address_pkg::STACK_LOW_OFFSET: begin
					next_s.rdata = s.sp[7:0];
				end
				default: begin
					next_s.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			// Software must load the stack pointer; this value is not a promise.
			s.sp <= operand_address_pkg::STACK_RESET; // see RULE9
			s.slice_first <= operand_address_pkg::SLICE_FIRST_RESET;
			s.slice_second <= operand_address_pkg::SLICE_SECOND_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end

endmodule : operand_address_generator

// ### hw/operand_address_pkg.sv
// Shared constants, types and carriers of the operand address generator.
package operand_address_pkg;

	localparam logic [7:0] SLICE_FIRST_OFFSET = 8'hd6;
	localparam logic [7:0] SLICE_SECOND_OFFSET = 8'hd7;
	localparam logic [7:0] STACK_HIGH_OFFSET = 8'hd8;
	localparam logic [7:0] STACK_LOW_OFFSET = 8'hd9;
	localparam logic [7:0] SLICE_FIRST_RESET = 8'hc0;
	localparam logic [7:0] SLICE_SECOND_RESET = 8'hc8;
	localparam logic [15:0] STACK_RESET = 16'h0000;
	localparam logic [3:0] WORK_PREFIX = 4'hc;
	localparam logic [7:0] SYSTEM_AREA_BASE = 8'hc0;
	localparam logic [7:0] VECTOR_PAGE = 8'h00;
	localparam logic [1:0] CALL_BYTES = 2'h2;
	localparam logic [1:0] INTERRUPT_BYTES = 2'h3;
	localparam logic [1:0] SINGLE_BYTE = 2'h1;

	typedef enum logic [3:0] {
		MODE_WORK4 = 4'h0,
		MODE_REG8 = 4'h1,
		MODE_POINTER_REG = 4'h2,
		MODE_POINTER_PAIR = 4'h3,
		MODE_INDEX_REG = 4'h4,
		MODE_INDEX_SHORT = 4'h5,
		MODE_INDEX_LONG = 4'h6,
		MODE_ABSOLUTE = 4'h7,
		MODE_VECTOR = 4'h8,
		MODE_PC_OFFSET = 4'h9
	} mode_t;

	typedef enum logic [3:0] {
		INSN_LOAD = 4'h0,
		INSN_PROGRAM_MEMORY_LOAD = 4'h1,
		INSN_EXTERNAL_DATA_LOAD = 4'h2,
		INSN_ABSOLUTE_JUMP = 4'h3,
		INSN_CALL = 4'h4,
		INSN_RELATIVE_JUMP = 4'h5,
		INSN_BIT_FALSE_REL_JUMP = 4'h6,
		INSN_BIT_TRUE_REL_JUMP = 4'h7,
		INSN_DECREMENT_NONZERO_JUMP = 4'h8,
		INSN_COMPARE_INC_EQUAL_JUMP = 4'h9,
		INSN_COMPARE_INC_UNEQUAL_JUMP = 4'ha,
		INSN_OTHER = 4'hb
	} insn_t;

	typedef enum logic [2:0] {
		CMD_ADDRESS = 3'h0,
		CMD_PUSH = 3'h1,
		CMD_POP = 3'h2,
		CMD_CALL = 3'h3,
		CMD_RETURN = 3'h4,
		CMD_INTERRUPT = 3'h5,
		CMD_RETURN_FROM_INTERRUPT = 3'h6
	} stack_cmd_t;

	typedef enum logic [1:0] {
		SPACE_REGISTER = 2'h0,
		SPACE_PROGRAM = 2'h1,
		SPACE_EXTERNAL = 2'h2,
		SPACE_PC = 2'h3
	} space_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_PUSH = 2'h1,
		ST_POP = 2'h2,
		ST_POP_END = 2'h3
	} state_t;

	typedef struct packed {
		logic valid;
		stack_cmd_t cmd;
		mode_t mode;
		insn_t insn;
		logic [7:0] operand;
		logic [15:0] word;
		logic [7:0] value_high;
		logic [7:0] value_low;
		logic [15:0] pc;
		logic [7:0] flags;
		logic [7:0] push_data;
	} request_t;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		space_t space;
		logic bad;
	} result_t;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic read;
		logic [7:0] wdata;
	} stack_port_t;

	typedef struct packed {
		logic pc_load;
		logic [15:0] pc;
		logic flags_load;
		logic [7:0] flags;
		logic pop_valid;
		logic [7:0] pop_data;
	} restore_t;

	typedef struct packed {
		state_t state;
		stack_cmd_t cmd;
		logic [1:0] count;
		logic [23:0] bytes;
		logic [23:0] gather;
		logic pending;
		logic [15:0] sp;
		logic [7:0] slice_first;
		logic [7:0] slice_second;
		logic [7:0] rdata;
		result_t res;
		stack_port_t stk;
		restore_t rest;
	} core_state_t;

endpackage : operand_address_pkg

// ### test/stack_file_model.sv
// Register file stand-in that serves the stack port of the generator.
`timescale 1ns/100ps
module stack_file_model (
	input wire logic sys_clk,
	input wire operand_address_pkg::stack_port_t stk,
	output logic [7:0] stk_rdata
);
	logic [7:0] mem [256];
	// The generator takes the byte at the end of the read pulse, so it is
	// served at once; outside the pulse the inverse shows a late sample.
	assign stk_rdata = stk.read ? mem[stk.addr] : ~mem[stk.addr];
	always @(posedge sys_clk) begin
		if (stk.write) begin
			mem[stk.addr] <= stk.wdata;
		end
	end
endmodule : stack_file_model

// ### test/operand_address_properties.sv
// Port checks of the operand address generator.
`timescale 1ns/100ps
module operand_address_properties (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire operand_address_pkg::request_t req,
	input wire logic req_ready,
	input wire operand_address_pkg::result_t res,
	input wire operand_address_pkg::stack_port_t stk,
	input wire logic [7:0] stk_rdata,
	input wire operand_address_pkg::restore_t rest,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic [7:0] first;
	logic [7:0] second;
	logic take;
	logic at;
	logic [15:0] work_addr;
	logic [15:0] rel_addr;
	// Shadow pointers let the address checks run without the design's state.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			first <= operand_address_pkg::SLICE_FIRST_RESET;
			second <= operand_address_pkg::SLICE_SECOND_RESET;
		end else if (reg_write && ce && reg_addr == 8'hd6) begin
			first <= reg_wdata;
		end else if (reg_write && ce && reg_addr == 8'hd7) begin
			second <= reg_wdata;
		end
	end
	assign take = req.valid && req_ready && ce;
	assign at = take && req.cmd == operand_address_pkg::CMD_ADDRESS;
	assign work_addr = {8'h00, (req.operand[3] ? second[7:3] : first[7:3]),
		req.operand[2:0]};
	assign rel_addr = req.pc + {{8{req.operand[7]}}, req.operand};
	sequence call_push;
		##2 stk.write && stk.wdata == $past(req.pc[7:0], 2)
		##1 stk.write && stk.wdata == $past(req.pc[15:8], 3) && res.valid
			&& stk.addr == $past(stk.addr) - 8'h01;
	endsequence
	sequence return_pop;
		##2 stk.read ##1 stk.read && stk.addr == $past(stk.addr) + 8'h01
		##1 rest.pc_load && res.valid;
	endsequence
	sequence interrupt_push;
		##2 stk.write [*2] ##1 stk.write && stk.wdata == $past(req.flags, 4);
	endsequence
	a_work4_addr: assert property (
		at && req.mode == operand_address_pkg::MODE_WORK4
		|=> res.valid && res.addr == $past(work_addr)) else $error("work4");
	a_work8_addr: assert property (
		at && req.mode == operand_address_pkg::MODE_REG8 && req.operand[7:4]
		== operand_address_pkg::WORK_PREFIX |=> res.addr == $past(work_addr))
		else $error("work8");
	a_absolute_addr: assert property (
		at && req.mode == operand_address_pkg::MODE_ABSOLUTE
		|=> res.valid && res.addr == $past(req.word)) else $error("absolute");
	a_relative_addr: assert property (
		at && req.mode == operand_address_pkg::MODE_PC_OFFSET
		|=> res.addr == $past(rel_addr)) else $error("relative");
	a_system_area: assert property (
		at && req.mode == operand_address_pkg::MODE_POINTER_REG
		&& req.value_low >= 8'hc0 |=> res.bad) else $error("system area");
	a_call_push: assert property (
		take && req.cmd == operand_address_pkg::CMD_CALL |-> call_push)
		else $error("call push");
	a_return_pop: assert property (
		take && req.cmd == operand_address_pkg::CMD_RETURN |-> return_pop)
		else $error("return pop");
	a_interrupt_push: assert property (
		take && req.cmd == operand_address_pkg::CMD_INTERRUPT
		|-> interrupt_push) else $error("interrupt push");
	a_rdata_idle: assert property (
		!$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data");
endmodule : operand_address_properties
bind operand_address_generator operand_address_properties chk (
	.sys_clk(sys_clk), .rst(rst), .ce(ce), .req(req),
	.req_ready(req_ready), .res(res), .stk(stk), .stk_rdata(stk_rdata),
	.rest(rest), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
);

// ### test/tb_top.sv
// Self-checking bench for the operand address generator.
`timescale 1ns/100ps
module tb_top;
	logic sys_clk;
	logic rst;
	logic ce;
	operand_address_pkg::request_t req;
	logic req_ready;
	operand_address_pkg::result_t res;
	operand_address_pkg::stack_port_t stk;
	logic [7:0] stk_rdata;
	operand_address_pkg::restore_t rest;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [7:0] reg_rdata;
	int mismatches;
	int compares;
	int cycles;
	logic [7:0] p0;
	logic [7:0] p1;
	logic [7:0] op;
	logic [7:0] ix;
	logic [7:0] d;
	logic [7:0] fl;
	logic [7:0] fs;
	logic [15:0] w;
	logic [15:0] pc;
	logic [15:0] ps;
	logic [15:0] pair;
	operand_address_pkg::result_t got;
	operand_address_pkg::restore_t back;
	operand_address_generator uut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.req(req), .req_ready(req_ready), .res(res), .stk(stk),
		.stk_rdata(stk_rdata), .rest(rest), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata));
	stack_file_model model (.sys_clk(sys_clk), .stk(stk),
		.stk_rdata(stk_rdata));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize
	// The ceiling is more than ten times the few hundred cycles the tests need.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			summarize();
		end
	end
	task automatic check(input string name, input logic [15:0] exp,
		input logic [15:0] act);
		compares++;
		if (act !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, act);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd
	function automatic operand_address_pkg::request_t mk(input logic [2:0] c,
		input logic [3:0] m, input logic [3:0] i, input logic [7:0] o,
		input logic [15:0] ww);
		mk = '0;
		mk.valid = 1'b1;
		mk.cmd = operand_address_pkg::stack_cmd_t'(c);
		mk.mode = operand_address_pkg::mode_t'(m);
		mk.insn = operand_address_pkg::insn_t'(i);
		mk.operand = o;
		mk.word = ww;
		mk.value_high = pair[15:8];
		mk.value_low = pair[7:0];
		mk.pc = pc;
		mk.flags = fl;
		mk.push_data = fl;
	endfunction : mk
	task automatic send(input operand_address_pkg::request_t r);
		int n;
		@(posedge sys_clk);
		req <= r;
		@(posedge sys_clk);
		req.valid <= 1'b0;
		n = 0;
		#1;
		while (res.valid !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check("result valid", 16'h0001, {15'h0000, res.valid});
		check("ready again", 16'h0001, {15'h0000, req_ready});
		got = res;
		back = rest;
	endtask : send
	task automatic ad(input logic [3:0] m, input logic [3:0] i,
		input logic [7:0] o, input logic [15:0] ea, input logic eb);
		send(mk(3'h0, m, i, o, w));
		check("bad", {15'h0000, eb}, {15'h0000, got.bad});
		if (!eb) begin
			check("address", ea, got.addr);
		end
	endtask : ad
	task automatic stack(input logic [2:0] c);
		send(mk(c, 4'h0, 4'hb, 8'h00, 16'h0000));
	endtask : stack
	function automatic logic [15:0] wk(input logic [3:0] n);
		wk = {8'h00, (n[3] ? p1[7:3] : p0[7:3]), n[2:0]};
	endfunction : wk
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		req = '0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		mismatches = 0;
		compares = 0;
		cycles = 0;
		pair = 16'h0000;
		pc = 16'h0000;
		fl = 8'h00;
		w = 16'h0000;
		void'($urandom(871));
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		p0 = 8'($urandom());
		p1 = 8'($urandom());
		wr(8'hd6, p0);
		wr(8'hd7, p1);
		rd(8'hd6, d);
		check("first pointer", {8'h00, p0}, {8'h00, d});
		rd(8'hd7, d);
		check("second pointer", {8'h00, p1}, {8'h00, d});
		rd(8'h3a, d);
		check("unmapped", 16'h0000, {8'h00, d});
		@(posedge sys_clk);
		ce <= 1'b0;
		wr(8'hd6, ~p0);
		ce <= 1'b1;
		rd(8'hd6, d);
		check("frozen pointer", {8'h00, p0}, {8'h00, d});
		$display("test registers done");
		for (int k = 0; k < 16; k++) begin
			ad(4'h0, 4'h0, {4'h0, k[3:0]}, wk(k[3:0]), 1'b0);
			ad(4'h1, 4'h0, {4'hc, k[3:0]}, wk(k[3:0]), 1'b0);
		end
		ad(4'h1, 4'h0, 8'h45, 16'h0045, 1'b0);
		$display("test working registers done");
		for (int i = 0; i < 12; i++) begin
			op = 8'($urandom());
			w = 16'($urandom());
			pair = 16'($urandom());
			pc = 16'($urandom());
			ix = op + pair[7:0];
			ad(4'h7, i[3:0], op, w, !(i inside {[1:4]}));
			ad(4'h8, i[3:0], op, {8'h00, op}, i != 4);
			ad(4'h9, i[3:0], op, pc + {{8{op[7]}}, op},
				!(i inside {[5:10]}));
			ad(4'h5, i[3:0], op, pair + {{8{op[7]}}, op},
				!(i inside {[1:2]}));
			ad(4'h6, i[3:0], op, pair + w, !(i inside {[1:2]}));
			ad(4'h4, i[3:0], op, {8'h00, ix},
				i != 0 || ix >= 8'hc0);
		end
		pair = 16'h34c0;
		ad(4'h2, 4'h0, 8'h00, 16'h0000, 1'b1);
		ad(4'h3, 4'h2, 8'h00, pair, 1'b0);
		check("pair space", {14'h0000, operand_address_pkg::SPACE_EXTERNAL},
			{14'h0000, got.space});
		pair = 16'h12bf;
		ad(4'h2, 4'h0, 8'h00, 16'h00bf, 1'b0);
		$display("test address modes done");
		wr(8'hd8, 8'h01);
		wr(8'hd9, 8'h00);
		ps = 16'($urandom());
		pc = ps;
		stack(3'h3);
		check("call sp", 16'h00fe, got.addr);
		rd(8'hd8, d);
		check("sp high", 16'h0000, {8'h00, d});
		pc = ~ps;
		stack(3'h4);
		check("return pc", ps, back.pc);
		check("pc load", 16'h0001, {15'h0000, back.pc_load});
		check("return sp", 16'h0100, got.addr);
		wr(8'hd8, 8'h00);
		wr(8'hd9, 8'hff);
		fs = 8'($urandom());
		fl = fs;
		pc = ps;
		stack(3'h5);
		check("interrupt sp", 16'h00fc, got.addr);
		fl = ~fs;
		pc = ~ps;
		stack(3'h6);
		check("restored pc", ps, back.pc);
		check("flags load", 16'h0001, {15'h0000, back.flags_load});
		check("restored flags", {8'h00, fs}, {8'h00, back.flags});
		check("return sp", 16'h00ff, got.addr);
		stack(3'h1);
		check("push sp", 16'h00fe, got.addr);
		fl = fs;
		stack(3'h2);
		check("pop data", {8'h00, ~fs}, {8'h00, back.pop_data});
		check("pop valid", 16'h0001, {15'h0000, back.pop_valid});
		stack(3'h2);
		check("pop sp", 16'h0100, got.addr);
		rd(8'hd8, d);
		check("carry high", 16'h0001, {8'h00, d});
		$display("test stack done");
		summarize();
	end
endmodule : tb_top
